// [rtl/drive_diagnostic_sequencer.sv]
module drive_diagnostic_sequencer
  import diag_pkg::*;
#(
  parameter int TRACKS  = DEF_TRACKS,
  parameter int SECTORS = DEF_SECTORS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] routine_code,
  input  wire logic       drive_ack,
  input  wire logic [3:0] drive_status,
  input  wire logic       density_dd,
  input  wire logic [7:0] read_sig,
  output cmd_type         cmd_kind,
  output logic            cmd_req,
  output logic [6:0]      cmd_track,
  output logic [4:0]      cmd_sector,
  output logic [7:0]      wr_data,
  output logic            media_dd,
  output logic            head_load,
  output logic [9:1]      lamp
);

  localparam logic [6:0] IDX_LAST    = 7'(TRACKS - 1);
  localparam logic [4:0] SECTOR_LAST = 5'(SECTORS);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic known_code(input logic [4:0] c);
    return (c == CODE_SEQ_SCAN) || (c == CODE_BFLY) || (c == CODE_WRRD) ||
           (c == CODE_FORMAT) || (c == CODE_SET_SD) || (c == CODE_SET_DD);
  endfunction

  function automatic logic write_code(input logic [4:0] c);
    return (c == CODE_WRRD) || (c == CODE_FORMAT) ||
           (c == CODE_SET_SD) || (c == CODE_SET_DD);
  endfunction

  // Index 0 is home; then alternate high and low ends
  function automatic logic [6:0] track_of(input logic [6:0] i, input logic bfly);
    logic [6:0] j;
    j = i - 7'h01;
    if (!bfly || i == TRACK_HOME)
      return i;
    return j[0] ? 7'(TRACK_FIRST + (j >> 1)) : 7'(IDX_LAST - (j >> 1));
  endfunction

  function automatic logic [7:0] pattern_of(input logic [6:0] t, input logic [4:0] s);
    return PAT_SEED ^ 8'({1'b0, t} * PAT_MUL_TRK) ^ 8'({3'h0, s} * PAT_MUL_SEC);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_type  state;
  logic       started;
  logic [4:0] code_q;
  logic       wpass;
  logic [6:0] idx;
  logic [4:0] sector;
  logic [3:0] halt_code;

  wire        bfly       = (code_q == CODE_BFLY) && !wpass;
  wire [6:0]  cur_track  = track_of(idx, bfly);
  wire        verify     = (code_q == CODE_WRRD) && !wpass;
  wire        need_dens  = !wpass || (code_q == CODE_WRRD);
  wire        ack        = cmd_req && drive_ack;
  wire        fault      = drive_status != STATUS_OK;
  wire        mismatch   = verify && (cmd_kind == CMD_READ) && (read_sig != wr_data);
  wire        last_sec   = sector == SECTOR_LAST;
  wire        last_idx   = idx == IDX_LAST;
  wire        active     = started && (state != ST_HALT);

  // Write pass kind chosen by routine; reads ignore data unless verifying
  cmd_type xfer_kind;
  always_comb begin
    xfer_kind = CMD_READ;
    if (wpass) begin
      case (code_q)
        CODE_WRRD:   xfer_kind = CMD_WRITE;
        CODE_FORMAT: xfer_kind = CMD_FORMAT;
        CODE_SET_SD: xfer_kind = CMD_DATA_SD;
        CODE_SET_DD: xfer_kind = CMD_DATA_DD;
        default:     xfer_kind = CMD_READ;
      endcase
    end
  end

  cmd_type next_kind;
  always_comb begin
    case (state)
      ST_DENS: next_kind = CMD_DETECT;
      ST_XFER: next_kind = xfer_kind;
      default: next_kind = CMD_SEEK;
    endcase
  end

  // Lamp 9 green while running; 5-8 show track bits then the halt code
  logic [9:1] next_lamp;
  always_comb begin
    if (!started)
      next_lamp = '0;
    else if (state == ST_HALT)
      next_lamp = {1'b0, halt_code, 4'h0};
    else
      next_lamp = {1'b1, cur_track[3:0], !wpass, wpass, 1'b0, media_dd};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= ST_HOME;
      started    <= 1'b0;
      code_q     <= 5'h00;
      wpass      <= 1'b0;
      idx        <= TRACK_HOME;
      sector     <= SECTOR_FIRST;
      halt_code  <= STATUS_OK;
      cmd_req    <= 1'b0;
      cmd_kind   <= CMD_SEEK;
      cmd_track  <= TRACK_HOME;
      cmd_sector <= SECTOR_FIRST;
      wr_data    <= 8'h00;
      media_dd   <= 1'b0;
      head_load  <= 1'b0;
      lamp       <= '0;
    end else begin
      lamp <= next_lamp;
      if (!started) begin
        // Selector is only meaningful in the first cycle after reset
        started <= 1'b1;
        code_q  <= routine_code;
        wpass   <= write_code(routine_code);
        if (!known_code(routine_code)) begin
          state     <= ST_HALT;
          halt_code <= ERR_SELECT;
        end
      end else if (ack && (fault || mismatch)) begin
        state     <= ST_HALT;
        halt_code <= fault ? drive_status : ERR_COMPARE;
        cmd_req   <= 1'b0;
        head_load <= 1'b0;
      end else if (active && !cmd_req) begin
        cmd_req    <= 1'b1;
        cmd_kind   <= next_kind;
        cmd_track  <= cur_track;
        cmd_sector <= sector;
        wr_data    <= pattern_of(cur_track, sector);
      end else if (ack) begin
        cmd_req <= 1'b0;
        case (state)
          ST_HOME: begin
            head_load <= 1'b1;
            state     <= need_dens ? ST_DENS : ST_SEEK;
          end
          ST_DENS: begin
            media_dd <= density_dd;
            state    <= ST_SEEK;
          end
          ST_SEEK: state <= ST_XFER;
          ST_XFER: begin
            if (!last_sec) begin
              sector <= sector + 5'h01;
            end else begin
              sector <= SECTOR_FIRST;
              if (!last_idx) begin
                idx   <= idx + 7'h01;
                state <= ST_SEEK;
              end else begin
                // Pass over: any write pass ends; scan repeats from home
                idx   <= TRACK_HOME;
                wpass <= 1'b0;
                state <= ST_HOME;
              end
            end
          end
          default: state <= ST_HALT;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_HALT_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_HALT |=> !cmd_req && !head_load)
    else $error("drive activity after halt");

  AST_HALT_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_HALT ##1 state == ST_HALT |=> state == ST_HALT && $stable(lamp))
    else $error("halt display not held");

  AST_FAULT_CODE: assert property (@(posedge clk) disable iff (!rst_n)
    started && state != ST_HALT && cmd_req && drive_ack && drive_status != STATUS_OK
    |=> state == ST_HALT ##1 lamp[8:5] == $past(drive_status, 2))
    else $error("fault code not shown on lamps");

  AST_GREEN_DARK: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_HALT |=> !lamp[9] && !(cmd_req && cmd_kind == CMD_SEEK))
    else $error("green lamp lit in halt");

  AST_BFLY_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_SEEK && bfly && idx == 7'h01 |-> cur_track == IDX_LAST ##0
    track_of(7'h02, 1'b1) == TRACK_FIRST)
    else $error("butterfly order wrong");

  AST_COMPARE: assert property (@(posedge clk) disable iff (!rst_n)
    ack && mismatch && !fault |=> state == ST_HALT && halt_code == ERR_COMPARE)
    else $error("compare mismatch not halted");

  AST_SCAN_IGNORES_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    ack && !fault && !wpass && code_q != CODE_WRRD && state != ST_HALT
    |=> state != ST_HALT)
    else $error("scan halted without a drive fault");

  AST_WRITE_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
    started && !wpass |=> !wpass)
    else $error("write pass repeated");

  AST_LAMPS_READING: assert property (@(posedge clk) disable iff (!rst_n)
    started && $fell(wpass) |=> !lamp[3] && lamp[4] ##1 !lamp[3])
    else $error("progress lamps wrong after write pass");

  AST_DD_FIELD: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cmd_req) && state == ST_XFER && wpass && code_q == CODE_SET_DD
    |-> cmd_kind == CMD_DATA_DD)
    else $error("wrong data field kind");

  AST_HOME_TRACK: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cmd_req) && state == ST_HOME |-> cmd_track == TRACK_HOME && cmd_kind == CMD_SEEK)
    else $error("pass does not start at track 00");

endmodule // drive_diagnostic_sequencer

// [inc/diag_pkg.sv]
package diag_pkg;

  // Routine codes from the five-bit selector
  localparam logic [4:0] CODE_SEQ_SCAN = 5'h12;
  localparam logic [4:0] CODE_BFLY     = 5'h13;
  localparam logic [4:0] CODE_WRRD     = 5'h18;
  localparam logic [4:0] CODE_FORMAT   = 5'h19;
  localparam logic [4:0] CODE_SET_SD   = 5'h1A;
  localparam logic [4:0] CODE_SET_DD   = 5'h1B;

  // Geometry defaults
  localparam int          DEF_TRACKS   = 77;
  localparam int          DEF_SECTORS  = 26;
  localparam logic [6:0]  TRACK_HOME   = 7'h00;
  localparam logic [6:0]  TRACK_FIRST  = 7'h01;
  localparam logic [4:0]  SECTOR_FIRST = 5'h01;

  // Data field contents of the set-density routines
  localparam int          SD_FIELD_BYTES = 128;
  localparam int          DD_FIELD_BYTES = 256;
  localparam int          CRC_BYTES      = 2;

  // Halt codes produced by the sequencer itself
  localparam logic [3:0]  ERR_COMPARE  = 4'hE;
  localparam logic [3:0]  ERR_SELECT   = 4'hF;
  localparam logic [3:0]  STATUS_OK    = 4'h0;

  // Pattern generator seed and multipliers
  localparam logic [7:0]  PAT_SEED     = 8'hA5;
  localparam logic [7:0]  PAT_MUL_TRK  = 8'h1D;
  localparam logic [7:0]  PAT_MUL_SEC  = 8'h3B;

  typedef enum logic [2:0] {
    CMD_SEEK    = 3'h0,
    CMD_DETECT  = 3'h1,
    CMD_READ    = 3'h2,
    CMD_WRITE   = 3'h3,
    CMD_FORMAT  = 3'h4,
    CMD_DATA_SD = 3'h5,
    CMD_DATA_DD = 3'h6
  } cmd_type;

  // Gray along home, density, seek, transfer; halt off the path
  typedef enum logic [2:0] {
    ST_HOME = 3'h0,
    ST_DENS = 3'h1,
    ST_SEEK = 3'h3,
    ST_XFER = 3'h2,
    ST_HALT = 3'h6
  } state_type;

endpackage

// [tb/drive_model.sv]
module drive_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_req,
  input  wire logic [7:0]  wr_data,
  input  wire logic [3:0]  ack_delay,
  input  wire logic [3:0]  fault_code,
  input  wire logic [15:0] fault_at,
  input  wire logic        corrupt,
  input  wire logic        dd,
  output logic             drive_ack,
  output logic [3:0]       drive_status,
  output logic             density_dd,
  output logic [7:0]       read_sig
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  wait_cnt;
  logic [15:0] acks;
  //////////////////////////////////////////////////////////////////////////////
  // Lines flip outside an answer, so a stale value never passes by luck
  always @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      acks <= 16'h0000;
      drive_ack <= 1'b0;
      drive_status <= 4'h5;
      density_dd <= 1'b0;
      read_sig <= 8'h3C;
    end else if (cmd_req && !drive_ack && wait_cnt >= ack_delay) begin
      drive_ack <= 1'b1;
      drive_status <= (acks == fault_at) ? fault_code : 4'h0;
      density_dd <= dd;
      read_sig <= corrupt ? ~wr_data : wr_data;
      acks <= acks + 16'h0001;
      wait_cnt <= 4'h0;
    end else begin
      drive_ack <= 1'b0;
      drive_status <= ~drive_status;
      density_dd <= ~density_dd;
      read_sig <= ~read_sig;
      if (cmd_req && !drive_ack)
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // drive_model

// [tb/test_drive_diagnostic_sequencer.sv]
module test_drive_diagnostic_sequencer import diag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, corrupt = 1'b0, dd = 1'b0;
  logic [4:0] routine_code = 5'h00;
  logic [3:0] ack_delay = 4'h0, fault_code = 4'h0;
  logic [15:0] fault_at = 16'hFFFF;
  logic drive_ack, density_dd, cmd_req, media_dd, head_load;
  logic [3:0] drive_status;
  logic [7:0] read_sig, wr_data;
  logic [6:0] cmd_track;
  logic [4:0] cmd_sector;
  logic [9:1] lamp;
  cmd_type cmd_kind;
  logic [22:0] log[$];
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #5 clk = ~clk;
  drive_diagnostic_sequencer drive_diagnostic_sequencer_inst (.clk(clk), .rst_n(rst_n),
    .routine_code(routine_code), .drive_ack(drive_ack), .drive_status(drive_status),
    .density_dd(density_dd), .read_sig(read_sig), .cmd_kind(cmd_kind), .cmd_req(cmd_req),
    .cmd_track(cmd_track), .cmd_sector(cmd_sector), .wr_data(wr_data),
    .media_dd(media_dd), .head_load(head_load), .lamp(lamp));
  drive_model drive_model_inst (.clk(clk), .rst_n(rst_n), .cmd_req(cmd_req),
    .wr_data(wr_data), .ack_delay(ack_delay), .fault_code(fault_code), .fault_at(fault_at),
    .corrupt(corrupt), .dd(dd), .drive_ack(drive_ack), .drive_status(drive_status),
    .density_dd(density_dd), .read_sig(read_sig));
  always @(posedge clk) begin
    if (rst_n && cmd_req && drive_ack) log.push_back({cmd_kind, cmd_track, cmd_sector, wr_data});
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start(input logic [4:0] code, input logic [3:0] dl, input logic c);
    @(posedge clk) #1;
    rst_n = 1'b0;
    routine_code = code;
    ack_delay = dl;
    corrupt = c;
    fault_at = 16'hFFFF;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    log.delete();
  endtask
  task automatic wait_for(input int n);
    while (log.size() < n) @(posedge clk);
    #1;
  endtask
  // Per track: one seek then sectors 1..26; pattern only checked when asked
  task automatic check_pass(input int b, input bit bfly, input logic [2:0] k, input bit data);
    logic [6:0] t;
    logic [7:0] w;
    for (int i = 0; i < 77; i++) begin
      t = bfly ? ((i % 2) ? 7'(76 - i / 2) : 7'(i / 2)) : 7'(i);
      chk("seek", {CMD_SEEK, t}, log[b + i * 27][22:13]);
      for (int s = 1; s <= 26; s++) begin
        w = PAT_SEED ^ ({1'b0, t} * PAT_MUL_TRK) ^ (8'(s) * PAT_MUL_SEC);
        chk("xfer", data ? {k, t, 5'(s), w} : {k, t, 5'(s)},
            data ? log[b + i * 27 + s] : log[b + i * 27 + s][22:8]);
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic seq_scan(input logic [4:0] code, input bit bfly, input logic d);
    dd = d;
    start(code, 4'h2, 1'b1);
    wait_for(2083);
    chk("home", {CMD_SEEK, TRACK_HOME}, log[0][22:13]);
    chk("detect", CMD_DETECT, log[1][22:20]);
    check_pass(2, bfly, CMD_READ, 1'b0);
    chk("rehome", {CMD_SEEK, TRACK_HOME, CMD_DETECT}, {log[2081][22:13], log[2082][22:20]});
    chk("running", {1'b1, 4'h0, 1'b0, d, d, 1'b1},
        {lamp[9], lamp[8:5], lamp[2:1], media_dd, head_load});
  endtask
  task automatic fault_halt();
    start(CODE_SEQ_SCAN, 4'h0, 1'b0);
    fault_code = 4'h9;
    fault_at = 16'd40;
    wait_for(41);
    repeat (60) @(posedge clk);
    #1;
    chk("halt", {1'b0, 4'h9, 2'b00}, {lamp[9], lamp[8:5], cmd_req, head_load});
    chk("still", 41, log.size());
    start(5'h00, 4'h0, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    chk("badcode", {1'b0, ERR_SELECT, 6'h00}, {lamp[9], lamp[8:5], 6'(log.size())});
  endtask
  task automatic write_read();
    dd = 1'b1;
    start(CODE_WRRD, 4'h1, 1'b0);
    wait_for(30);
    chk("wlamps", 2'b01, lamp[4:3]);
    wait_for(4166);
    chk("rlamps", 2'b10, lamp[4:3]);
    check_pass(2, 1'b0, CMD_WRITE, 1'b1);
    check_pass(2083, 1'b0, CMD_READ, 1'b1);
    chk("again", {CMD_SEEK, TRACK_HOME, CMD_DETECT, CMD_READ},
        {log[4162][22:13], log[4163][22:20], log[4165][22:20]});
    corrupt = 1'b1;
    repeat (30) @(posedge clk);
    #1;
    chk("cmpfail", {1'b0, ERR_COMPARE, 1'b0}, {lamp[9], lamp[8:5], cmd_req});
  endtask
  task automatic utilities();
    logic [4:0] codes[3] = '{CODE_FORMAT, CODE_SET_SD, CODE_SET_DD};
    logic [2:0] kinds[3] = '{CMD_FORMAT, CMD_DATA_SD, CMD_DATA_DD};
    for (int u = 0; u < 3; u++) begin
      start(codes[u], 4'h0, 1'b0);
      wait_for(10);
      chk("ulamp", 2'b01, lamp[4:3]);
      wait_for(2084);
      check_pass(1, 1'b0, kinds[u], 1'b0);
      chk("toscan", {CMD_DETECT, CMD_READ}, {log[2081][22:20], log[2083][22:20]});
      chk("slamp", 2'b10, lamp[4:3]);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    seq_scan(CODE_SEQ_SCAN, 1'b0, 1'b1);
    seq_scan(CODE_BFLY, 1'b1, 1'b0);
    fault_halt();
    write_read();
    utilities();
    wrap_up();
  end
endmodule // test_drive_diagnostic_sequencer
